// ===== hw/scic_pkg.sv
// Package: register map, fields, reset values and carriers of the card interface
package scic_pkg;

   // ==========================================
   // Register addresses (special function space)
   localparam logic [7:0] ADDR_SELECT_CFG = 8'hAB;
   localparam logic [7:0] ADDR_CONTACTS   = 8'hAC;
   localparam logic [7:0] ADDR_STATUS     = 8'hAD;
   localparam logic [7:0] ADDR_IRQ        = 8'hAE;
   localparam logic [7:0] ADDR_BUFFER     = 8'hAA;
   localparam logic [7:0] ADDR_WT0        = 8'hB4;
   localparam logic [7:0] ADDR_WT1        = 8'hB5;
   localparam logic [7:0] ADDR_WT2_CTRL   = 8'hB6;

   // ==========================================
   // Reset values
   localparam logic [7:0]  RST_CONTROL  = 8'h00;
   localparam logic [7:0]  RST_CONTACTS = 8'h00;
   localparam logic [7:0]  RST_STATUS   = 8'h80;
   localparam logic [7:0]  RST_IRQ      = 8'h00;
   localparam logic [7:0]  RST_IRQ_EN   = 8'h00;
   localparam logic [7:0]  RST_SELECT   = 8'h08;
   localparam logic [7:0]  RST_WT0      = 8'h80;
   localparam logic [7:0]  RST_WT1      = 8'h25;
   localparam logic [7:0]  RST_WT2      = 8'h00;
   localparam logic [23:0] WT_TIMEOUT   = 24'h000000;

   // ==========================================
   // Field positions
   localparam int CTL_RESET = 7;
   localparam int CTL_UART  = 3;
   localparam int CTL_WAIT_COUNTER_ENABLE  = 2;
   localparam int CTL_CHAR_REPEAT_ENABLE  = 1;
   localparam int CTL_CONVENTION_SELECT  = 0;
   localparam int CON_CLKSEL = 7;
   localparam int CON_C8     = 5;
   localparam int CON_C4     = 4;
   localparam int CON_IO     = 3;
   localparam int CON_CLK    = 2;
   localparam int CON_RST    = 1;
   localparam int CON_VCC    = 0;
   localparam int ST_TBE  = 7;
   localparam int ST_IN   = 6;
   localparam int ST_OVF  = 5;
   localparam int ST_VOK  = 4;
   localparam int ST_WTO  = 3;
   localparam int ST_TC   = 2;
   localparam int ST_RC   = 1;
   localparam int ST_PE   = 0;
   localparam int IR_TB   = 7;
   localparam int IR_CERR = 5;
   localparam int IR_VERR = 4;
   localparam int IR_WT   = 3;
   localparam int IR_TX   = 2;
   localparam int IR_RX   = 1;
   localparam int IR_PE   = 0;
   localparam int SEL_REPSEL = 4;
   localparam int SEL_DIV_LO = 2;
   localparam int SEL_ALTCLK = 1;
   localparam int SEL_BANK   = 0;
   localparam logic [7:0] IRQ_VALID_MASK = 8'hBF;

   // Parity indication limits
   localparam logic [2:0] RX_SIGNAL_MAX = 3'h3;
   localparam logic [2:0] TX_REPEAT_MAX = 3'h3;
   localparam logic [2:0] TX_FLAG_5     = 3'h5;
   localparam logic [2:0] TX_FLAG_4     = 3'h4;

   // ==========================================
   // Carrier types
   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] wdata;
      logic       wr;
      logic       rd;
   } scic_bus_t;

   typedef struct packed {
      logic tx_loaded;     // buffer moved to shift register
      logic tx_done;       // character sent
      logic rx_done;       // character received
      logic rx_parity_bad; // parity mismatch seen on receive
      logic tx_parity_nak; // card flagged error on transmit
      logic start_bit;     // start bit sent or received
      logic etu_tick;      // one elementary time unit elapsed
   } scic_uart_ev_t;

   typedef struct packed {
      logic card_in;
      logic overcurrent;
      logic voltage_good;
      logic current_err;
      logic voltage_err;
   } scic_analog_t;

endpackage

// ===== hw/scic_regs.sv
// Card interface control and status register bank with contact pin steering
// Notes on behaviour
// - Direct convention: LSB first, low is zero
// - Inverse convention: MSB first, parity after b0
// - Repetition off: no parity signalling or resend
// - Receive: signal error thrice, flag fourth
// - Transmit: resend flagged character up to thrice
// - Count select: flag after five or four
// - I/O pin from UART or contact bit
// - Counter stopped; WT2 write loads hold regs
// - Enable starts counter; stops at timeout
// - UART mode reloads counter on start bit
// - Glitch-free card clock source switch
// - C4, C8, reset pins follow contact bits
// - Supply bit off disables all contacts
// - Transmit buffer empty set on load, cleared on write
// - Receive flag cleared by buffer read
// - Presence, overcurrent and error flags
// - Identification flags cleared on read
// - Each cause gated by its enable
// - Alternate clock divides 1/2/4/8, reset 4
// - Alternate clock pin or port function
// - Bank bit selects shared-address register
// - One active-high interrupt, cleared by read
// - Event during read lands after read
`timescale 1ns/100ps
module scic_regs #(
   parameter int WT_WIDTH = 24
) (
   input  wire logic                   core_clk,
   input  wire logic                   sys_rst,
   input  wire scic_pkg::scic_bus_t    bus,
   output logic [7:0]                  rdata,
   input  wire scic_pkg::scic_uart_ev_t uart_ev,
   input  wire logic [7:0]             rx_data,
   input  wire logic                   uart_io_out,
   input  wire scic_pkg::scic_analog_t analog_pin,
   input  wire logic                   xtal_clk_en,
   input  wire logic                   card_voltage_ready,
   input  wire logic                   card_io_pin_in,
   output logic                        card_io_in,
   output logic [7:0]                  tx_buffer,
   output logic                        tx_buffer_write,
   output logic                        convention_select,
   output logic                        char_repeat_enable,
   output logic                        rx_signal_error,
   output logic                        tx_resend,
   output logic                        xfer_abort,
   output logic                        card_io_out,
   output logic                        card_io_oe_n,
   output logic                        card_clk,
   output logic                        card_rst,
   output logic                        card_c4,
   output logic                        card_c8,
   output logic                        card_supply_on,
   output logic [1:0]                  card_voltage_select,
   output logic                        detect_polarity,
   output logic                        alt_card_clock,
   output logic                        alt_clock_out_select,
   output logic                        irq
);

   // ==========================================
   // Pin synchronisers
   scic_pkg::scic_analog_t ana_s1, ana_s2;
   logic                   io_s1, io_s2;

   always_ff @(posedge core_clk) begin
      ana_s1 <= analog_pin;
      ana_s2 <= ana_s1;
      io_s1  <= card_io_pin_in;
      io_s2  <= io_s1;
   end

   // ==========================================
   // Register state
   logic [7:0]          control, contacts, status, ident, irq_en, select;
   logic [7:0]          wt0, wt1, wt2, rxbuf;
   logic [WT_WIDTH-1:0] wt_hold, wt_cnt;
   logic                wt_run, wt_en_d, irq_q;
   logic [2:0]          pe_cnt, div_cnt;
   logic [7:0]          pend, next_pend;
   logic                clk_sel_q, clk_q, alt_q;
   logic [7:0]          next_control, next_contacts, next_status, next_ident, next_irq_en, next_select;
   logic [7:0]          next_wt0, next_wt1, next_wt2, next_rxbuf;
   logic [WT_WIDTH-1:0] next_wt_hold, next_wt_cnt;
   logic                next_wt_run, next_irq;
   logic [2:0]          next_pe_cnt, next_div_cnt;
   logic                next_clk_sel, next_clk, next_alt;

   logic bank, sel_ctl, wr_buf, rd_buf, rd_ident, wt_timeout, soft_rst;
   logic [7:0] ev;
   logic [2:0] tx_limit;

   assign bank     = select[scic_pkg::SEL_BANK];
   assign sel_ctl  = bus.addr == scic_pkg::ADDR_WT2_CTRL && bank;
   assign wr_buf   = bus.wr && bus.addr == scic_pkg::ADDR_BUFFER && !bank;
   assign rd_buf   = bus.rd && bus.addr == scic_pkg::ADDR_BUFFER && bank;
   assign rd_ident = bus.rd && bus.addr == scic_pkg::ADDR_IRQ && !bank;
   assign soft_rst = control[scic_pkg::CTL_RESET];

   assign wt_timeout = wt_run && wt_cnt == WT_WIDTH'(scic_pkg::WT_TIMEOUT);
   assign tx_limit = select[scic_pkg::SEL_REPSEL] ? scic_pkg::TX_FLAG_4 : scic_pkg::TX_FLAG_5;

   // Events in ident bit order
   always_comb begin
      ev = 8'h00;
      ev[scic_pkg::IR_TB]   = uart_ev.tx_loaded;
      ev[scic_pkg::IR_CERR] = ana_s2.current_err;
      ev[scic_pkg::IR_VERR] = ana_s2.voltage_err;
      ev[scic_pkg::IR_WT]   = wt_timeout;
      ev[scic_pkg::IR_TX]   = uart_ev.tx_done;
      ev[scic_pkg::IR_RX]   = uart_ev.rx_done;
      ev[scic_pkg::IR_PE]   = 1'b0;

      if (char_repeat_enable) begin
         if (uart_ev.rx_parity_bad && pe_cnt >= scic_pkg::RX_SIGNAL_MAX)
            ev[scic_pkg::IR_PE] = 1'b1;
         if (uart_ev.tx_parity_nak && pe_cnt + 3'h1 >= tx_limit)
            ev[scic_pkg::IR_PE] = 1'b1;
      end
   end

   // Parity repetition outputs and transfer abort
   assign rx_signal_error = char_repeat_enable && uart_ev.rx_parity_bad
                            && pe_cnt < scic_pkg::RX_SIGNAL_MAX;
   assign tx_resend       = char_repeat_enable && uart_ev.tx_parity_nak
                            && pe_cnt < scic_pkg::TX_REPEAT_MAX;
   assign xfer_abort      = soft_rst || wt_timeout || status[scic_pkg::ST_WTO];

   // ==========================================
   // Next-state logic
   always_comb begin
      next_control  = control;
      next_contacts = contacts;
      next_irq_en   = irq_en;
      next_select   = select;
      next_wt0      = wt0;
      next_wt1      = wt1;
      next_wt2      = wt2;
      next_rxbuf    = rxbuf;

      next_wt_hold  = wt_hold;
      next_wt_cnt   = wt_cnt;
      next_wt_run   = wt_run;
      next_pe_cnt   = pe_cnt;

      next_status   = status;
      next_ident    = ident;

      if (bus.wr) begin
         case (bus.addr)
            scic_pkg::ADDR_SELECT_CFG: next_select = bus.wdata;
            scic_pkg::ADDR_CONTACTS:   if (!bank) next_contacts = bus.wdata & 8'hBF;
            scic_pkg::ADDR_IRQ:        if (bank) next_irq_en = bus.wdata & scic_pkg::IRQ_VALID_MASK;
            scic_pkg::ADDR_STATUS:     if (!bank) begin
               next_status[scic_pkg::ST_TC] = status[scic_pkg::ST_TC] & bus.wdata[scic_pkg::ST_TC];
               next_status[scic_pkg::ST_PE] = status[scic_pkg::ST_PE] & bus.wdata[scic_pkg::ST_PE];
            end
            scic_pkg::ADDR_WT0:        if (!bank) next_wt0 = bus.wdata;
            scic_pkg::ADDR_WT1:        if (!bank) next_wt1 = bus.wdata;
            scic_pkg::ADDR_WT2_CTRL:   if (sel_ctl) next_control = bus.wdata;
                                       else next_wt2 = bus.wdata;
            default: ;
         endcase
      end
      if (bus.wr && bus.addr == scic_pkg::ADDR_WT2_CTRL && !bank && !control[scic_pkg::CTL_WAIT_COUNTER_ENABLE])
         next_wt_hold = WT_WIDTH'({bus.wdata, wt1, wt0});

      // Wait counter
      if (control[scic_pkg::CTL_WAIT_COUNTER_ENABLE] && !wt_en_d) begin
         next_wt_cnt = wt_hold;
         next_wt_run = 1'b1;
      end else if (!control[scic_pkg::CTL_WAIT_COUNTER_ENABLE] || wt_timeout) begin
         next_wt_run = 1'b0;
      end else if (control[scic_pkg::CTL_UART] && uart_ev.start_bit) begin
         next_wt_cnt = wt_hold;
      end else if (wt_run && uart_ev.etu_tick) begin
         next_wt_cnt = wt_cnt - WT_WIDTH'(1);
      end

      // Consecutive parity indications
      if (char_repeat_enable && (uart_ev.rx_parity_bad || uart_ev.tx_parity_nak))
         next_pe_cnt = (ev[scic_pkg::IR_PE]) ? 3'h0 : pe_cnt + 3'h1;
      else if (uart_ev.rx_done || uart_ev.tx_done)
         next_pe_cnt = 3'h0;
      if (rd_buf)
         next_status[scic_pkg::ST_RC] = 1'b0;
      if (uart_ev.rx_done)
         next_rxbuf = rx_data;

      // Status: set wins over clear
      if (wr_buf)
         next_status[scic_pkg::ST_TBE] = 1'b0;
      if (uart_ev.tx_loaded)
         next_status[scic_pkg::ST_TBE] = 1'b1;

      next_status[scic_pkg::ST_IN]  = ana_s2.card_in;
      next_status[scic_pkg::ST_OVF] = ana_s2.overcurrent;
      next_status[scic_pkg::ST_VOK] = ana_s2.voltage_good;
      next_status[scic_pkg::ST_WTO] = wt_timeout | (status[scic_pkg::ST_WTO] & ~(control[scic_pkg::CTL_WAIT_COUNTER_ENABLE] & ~wt_en_d));

      if (uart_ev.tx_done) next_status[scic_pkg::ST_TC] = 1'b1;
      if (uart_ev.rx_done) next_status[scic_pkg::ST_RC] = 1'b1;
      if (ev[scic_pkg::IR_PE]) next_status[scic_pkg::ST_PE] = 1'b1;

      // Ident: read clears; events in a read cycle wait a cycle
      if (rd_ident)
         next_ident = 8'h00;
      else
         next_ident = ident | pend | ev;
      next_irq = |(next_ident & irq_en);
   end

   // Events in a read cycle land after it
   always_comb next_pend = rd_ident ? ev : 8'h00;

   always_ff @(posedge core_clk) begin
      if (sys_rst || soft_rst) begin
         control  <= scic_pkg::RST_CONTROL;
         contacts <= scic_pkg::RST_CONTACTS;
         status   <= scic_pkg::RST_STATUS;
         ident    <= scic_pkg::RST_IRQ;
         irq_en   <= scic_pkg::RST_IRQ_EN;
         select   <= scic_pkg::RST_SELECT;

         wt0      <= scic_pkg::RST_WT0;
         wt1      <= scic_pkg::RST_WT1;
         wt2      <= scic_pkg::RST_WT2;
         rxbuf    <= 8'h00;

         wt_hold  <= '0;
         wt_cnt   <= '0;
         wt_run   <= 1'b0;
         wt_en_d  <= 1'b0;

         pe_cnt   <= 3'h0;
         pend     <= 8'h00;
         irq_q    <= 1'b0;
      end else begin
         control  <= next_control;
         contacts <= next_contacts;
         status   <= next_status;
         ident    <= next_ident;
         irq_en   <= next_irq_en;
         select   <= next_select;

         wt0      <= next_wt0;
         wt1      <= next_wt1;
         wt2      <= next_wt2;
         rxbuf    <= next_rxbuf;

         wt_hold  <= next_wt_hold;
         wt_cnt   <= next_wt_cnt;
         wt_run   <= next_wt_run;
         wt_en_d  <= control[scic_pkg::CTL_WAIT_COUNTER_ENABLE];
         pe_cnt   <= next_pe_cnt;
         pend     <= next_pend;
         irq_q    <= next_irq;
      end
   end

   // ==========================================
   // Read data and buffer strobe
   always_comb begin
      rdata = 8'h00;
      case (bus.addr)
         scic_pkg::ADDR_SELECT_CFG: rdata = {3'h0, select[4:0]};
         scic_pkg::ADDR_CONTACTS:   rdata = bank ? 8'h00 : contacts;
         scic_pkg::ADDR_STATUS:     rdata = bank ? 8'h00 : status;
         scic_pkg::ADDR_IRQ:        rdata = bank ? irq_en : ident;
         scic_pkg::ADDR_BUFFER:     rdata = bank ? rxbuf : 8'h00;
         scic_pkg::ADDR_WT0:        rdata = bank ? 8'h00 : wt0;
         scic_pkg::ADDR_WT1:        rdata = bank ? 8'h00 : wt1;
         scic_pkg::ADDR_WT2_CTRL:   rdata = bank ? control : wt2;
         default:                   rdata = 8'h00;
      endcase
   end

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         tx_buffer       <= 8'h00;
         tx_buffer_write <= 1'b0;
      end else begin
         tx_buffer_write <= wr_buf;
         if (wr_buf) tx_buffer <= bus.wdata;
      end
   end

   assign convention_select  = control[scic_pkg::CTL_CONVENTION_SELECT];
   assign char_repeat_enable = control[scic_pkg::CTL_CHAR_REPEAT_ENABLE];
   assign card_voltage_select = control[5:4];
   assign detect_polarity    = control[6];

   assign irq                = irq_q;

   // ==========================================
   // Contact pins, gated by supply bit
   logic vcc_on;
   assign vcc_on         = contacts[scic_pkg::CON_VCC];
   assign card_supply_on = vcc_on;
   assign card_io_in     = io_s2;

   always_comb begin
      next_clk_sel = clk_sel_q;
      if (!clk_q) next_clk_sel = contacts[scic_pkg::CON_CLKSEL];

      next_clk = clk_sel_q ? xtal_clk_en : contacts[scic_pkg::CON_CLK];
      next_clk = next_clk & vcc_on;
   end

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         clk_sel_q    <= 1'b0;
         clk_q        <= 1'b0;

         card_rst     <= 1'b0;
         card_c4      <= 1'b0;
         card_c8      <= 1'b0;
         card_io_out  <= 1'b0;
         card_io_oe_n <= 1'b1;
      end else begin
         clk_sel_q    <= next_clk_sel;
         clk_q        <= next_clk;

         card_rst     <= vcc_on & contacts[scic_pkg::CON_RST];
         card_c4      <= vcc_on & contacts[scic_pkg::CON_C4];
         card_c8      <= vcc_on & contacts[scic_pkg::CON_C8];
         card_io_out  <= control[scic_pkg::CTL_UART] ? uart_io_out : contacts[scic_pkg::CON_IO];
         card_io_oe_n <= ~vcc_on;
      end
   end

   assign card_clk = clk_q;

   // ==========================================
   // Alternate card clock prescaler
   logic [1:0] div_code;
   assign div_code = select[scic_pkg::SEL_DIV_LO +: 2];
   always_comb begin
      next_div_cnt = 3'h0;
      next_alt     = alt_q;

      if (div_code == 2'h0) begin
         next_alt = xtal_clk_en;
      end else if (xtal_clk_en) begin
         next_div_cnt = div_cnt + 3'h1;
         if (div_cnt == 3'((1 << (div_code - 2'h1)) - 1)) begin
            next_div_cnt = 3'h0;
            next_alt     = ~alt_q;
         end
      end else begin
         next_div_cnt = div_cnt;
      end
   end

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         div_cnt <= 3'h0;
         alt_q   <= 1'b0;
      end else begin
         div_cnt <= next_div_cnt;
         alt_q   <= next_alt;
      end
   end

   assign alt_clock_out_select = select[scic_pkg::SEL_ALTCLK];
   assign alt_card_clock       = alt_q & alt_clock_out_select;

endmodule // scic_regs

// ===== verification/scic_card_model.sv
// Far-side model: engine events, crystal enable, pulled-up I/O
`timescale 1ns/100ps
module scic_card_model (
   input  wire logic                    core_clk,
   input  wire logic                    sys_rst,
   input  wire scic_pkg::scic_uart_ev_t ev_cmd,
   input  wire logic                    card_io_out,
   input  wire logic                    card_io_oe_n,
   output scic_pkg::scic_uart_ev_t      uart_ev,
   output logic                         xtal_clk_en,
   output logic                         card_io_pin_in
);
   always_ff @(posedge core_clk) begin
      uart_ev     <= sys_rst ? '0 : ev_cmd;
      xtal_clk_en <= !sys_rst && !xtal_clk_en;
   end
   // Released line floats high
   assign card_io_pin_in = card_io_oe_n | card_io_out;
endmodule // scic_card_model

// ===== verification/scic_monitor.sv
// Port checker for the card interface register bank
`timescale 1ns/100ps
module scic_monitor (
   input wire logic                    core_clk,
   input wire logic                    sys_rst,
   input wire scic_pkg::scic_bus_t     bus,
   input wire logic [7:0]              tx_buffer,
   input wire logic                    tx_buffer_write,
   input wire logic                    convention_select,
   input wire logic                    char_repeat_enable,
   input wire logic                    rx_signal_error,
   input wire logic                    tx_resend,
   input wire logic                    card_io_oe_n,
   input wire logic                    card_rst,
   input wire logic                    card_c4,
   input wire logic                    card_c8,
   input wire logic                    card_supply_on,
   input wire logic                    alt_card_clock,
   input wire logic                    alt_clock_out_select,
   input wire logic                    irq,
   input wire scic_pkg::scic_uart_ev_t uart_ev
);
   logic       bank, next_bank, wr_ctl, rd_id, wr_con;
   logic [7:0] ien, next_ien;
   // ==========================================
   // Shadow bank bit and enables
   assign wr_ctl = bus.wr && bank && bus.addr == scic_pkg::ADDR_WT2_CTRL;
   assign rd_id  = bus.rd && !bank && bus.addr == scic_pkg::ADDR_IRQ;
   assign wr_con = bus.wr && !bank && bus.addr == scic_pkg::ADDR_CONTACTS;
   always_comb begin
      next_bank = bank;
      next_ien  = ien;
      if (bus.wr && bus.addr == scic_pkg::ADDR_SELECT_CFG) next_bank = bus.wdata[0];
      if (bus.wr && bank && bus.addr == scic_pkg::ADDR_IRQ) next_ien = bus.wdata;
      if (wr_ctl && bus.wdata[7]) begin
         next_bank = 1'b0;
         next_ien  = 8'h00;
      end
   end
   always_ff @(posedge core_clk) begin
      bank <= sys_rst ? 1'b0 : next_bank;
      ien  <= sys_rst ? 8'h00 : next_ien;
   end
   // ==========================================
   // Properties
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (sys_rst);
   a_tx_buf_load: assert property (
      bus.wr && !bank && bus.addr == scic_pkg::ADDR_BUFFER |=> tx_buffer_write && tx_buffer == $past(bus.wdata))
      else $error("tx buffer write lost");
   a_ctl_bits: assert property (
      wr_ctl && !bus.wdata[7] |=> convention_select == $past(bus.wdata[0]) && char_repeat_enable == $past(bus.wdata[1]))
      else $error("control bits not applied");
   a_no_repeat: assert property (
      !char_repeat_enable |-> !rx_signal_error && !tx_resend) else $error("parity signalled while off");
   a_pin_drive: assert property (
      wr_con ##1 !bus.wr |-> ##1 card_c4 == $past(bus.wdata[4] & bus.wdata[0], 2)
         && card_c8 == $past(bus.wdata[5] & bus.wdata[0], 2) && card_rst == $past(bus.wdata[1] & bus.wdata[0], 2))
      else $error("contact pins wrong");
   a_supply_off: assert property (
      !card_supply_on && !$past(card_supply_on) |-> !card_c4 && !card_c8 && !card_rst && card_io_oe_n)
      else $error("pins active with supply off");
   a_irq_clear: assert property (
      rd_id && uart_ev == '0 ##1 uart_ev == '0 |=> !irq) else $error("irq kept after ident read");
   a_irq_mask: assert property (
      ien == 8'h00 && $past(ien) == 8'h00 |-> !irq) else $error("irq with all causes masked");
   a_alt_gate: assert property (
      !alt_clock_out_select && !$past(alt_clock_out_select) |-> !alt_card_clock) else $error("alt clock leaks");
   c_irq_read: cover property (rd_id && irq);
   c_resend: cover property (tx_resend);
   c_alt_clk: cover property ($rose(alt_card_clock));
endmodule // scic_monitor

bind scic_regs scic_monitor i_mon (.*);

// ===== verification/test_smart_card_interface_control.sv
// Self-checking bench for the card interface register bank
`timescale 1ns/100ps
module test_smart_card_interface_control;
   localparam logic [7:0] A_SEL = scic_pkg::ADDR_SELECT_CFG;
   localparam logic [7:0] A_CON = scic_pkg::ADDR_CONTACTS;
   localparam logic [7:0] A_ST  = scic_pkg::ADDR_STATUS;
   localparam logic [7:0] A_IR  = scic_pkg::ADDR_IRQ;
   localparam logic [7:0] A_CTL = scic_pkg::ADDR_WT2_CTRL;
   logic                    core_clk    = 1'b0;
   logic                    sys_rst     = 1'b1;
   scic_pkg::scic_bus_t     bus         = '0;
   scic_pkg::scic_uart_ev_t ev_cmd      = '0;
   scic_pkg::scic_analog_t  analog_pin  = '0;
   logic [7:0]              rx_data     = 8'h00;
   logic                    uart_io_out = 1'b0;
   scic_pkg::scic_uart_ev_t uart_ev;
   logic [7:0]              rdata, tx_buffer;
   logic tx_buffer_write, convention_select, char_repeat_enable, rx_signal_error, tx_resend, xfer_abort;
   logic card_io_out, card_io_oe_n, card_rst, card_c4, card_c8, card_supply_on, card_io_in;
   logic alt_card_clock, alt_clock_out_select, irq, xtal_clk_en, card_io_pin_in;
   int   err_count = 0;
   int   check_count = 0;

   always #2 core_clk = ~core_clk;

   scic_regs i_dut (.*, .card_voltage_ready(1'b1), .card_clk(), .card_voltage_select(), .detect_polarity());
   scic_card_model i_card (.*);

   // ==========================================
   // Bus, event and compare helpers
   task automatic cmp(string what, logic [7:0] exp, logic [7:0] got);
      check_count++;
      if (got !== exp) begin
         err_count++;
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic wr(logic [7:0] a, logic [7:0] d);
      @(posedge core_clk);
      bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge core_clk);
      bus.wr <= 1'b0;
      @(negedge core_clk);
   endtask
   task automatic chk(logic [7:0] a, logic [7:0] exp);
      @(posedge core_clk);
      bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
      @(posedge core_clk);
      cmp($sformatf("reg_%h", a), exp, rdata);
      bus.rd <= 1'b0;
      @(negedge core_clk);
   endtask
   // Event lands a cycle later; replies sampled then
   task automatic pulse(logic [6:0] e, output logic [1:0] s);
      @(posedge core_clk);
      ev_cmd <= scic_pkg::scic_uart_ev_t'(e);
      @(posedge core_clk);
      ev_cmd <= '0;
      @(negedge core_clk);
      s = {rx_signal_error, tx_resend};
      @(negedge core_clk);
   endtask
   task automatic chk_irq(logic e);
      for (int n = 0; n < 8 && irq !== e; n++) @(negedge core_clk);
      cmp("irq", {7'h00, e}, {7'h00, irq});
   endtask
   task automatic soft_reset();
      wr(A_SEL, 8'h09);
      wr(A_CTL, 8'h80);
      chk(A_SEL, 8'h08);
   endtask

   // ==========================================
   // Scenarios
   task automatic t_buffer();
      logic [1:0] s;
      chk(A_ST, 8'h80);
      chk(8'hB0, 8'h00);
      wr(A_SEL, 8'h09);
      wr(A_IR, 8'h80);
      wr(A_SEL, 8'h08);
      wr(scic_pkg::ADDR_BUFFER, 8'hA5);
      cmp("tx_buffer", 8'hA5, tx_buffer);
      chk(A_ST, 8'h00);
      pulse(7'h40, s);
      chk_irq(1'b1);
      chk(A_ST, 8'h80);
      chk(A_IR, 8'h80);
      chk_irq(1'b0);
   endtask
   task automatic t_irq();
      logic [1:0] s;
      wr(A_SEL, 8'h09);
      wr(A_IR, 8'h06);
      wr(A_SEL, 8'h08);
      pulse(7'h20, s);
      chk_irq(1'b1);
      chk(A_IR, 8'h04);
      wr(A_ST, 8'h00);
      @(posedge core_clk);
      rx_data <= 8'h3C;
      pulse(7'h10, s);
      chk(A_ST, 8'h82);
      chk(A_IR, 8'h02);
      wr(A_SEL, 8'h09);
      chk(scic_pkg::ADDR_BUFFER, 8'h3C);
      wr(A_IR, 8'h00);
      wr(A_SEL, 8'h08);
      chk(A_ST, 8'h80);
      pulse(7'h20, s);
      chk_irq(1'b0);
      chk(A_IR, 8'h04);
      wr(A_ST, 8'h00);
   endtask
   task automatic t_contacts();
      wr(A_CON, 8'h33);
      @(negedge core_clk);
      cmp("pins", 8'h0F, {4'h0, card_c8, card_c4, card_rst, card_supply_on});
      chk(A_CON, 8'h33);
      wr(A_CON, 8'h09);
      @(negedge core_clk);
      cmp("io_bit", 8'h01, {7'h00, card_io_out});
      wr(A_SEL, 8'h09);
      wr(A_CTL, 8'h08);
      wr(A_SEL, 8'h08);
      for (int v = 0; v < 2; v++) begin
         @(posedge core_clk);
         uart_io_out <= v[0];
         repeat (2) @(negedge core_clk);
         cmp("io_uart", {7'h00, v[0]}, {7'h00, card_io_out});
      end
      wr(A_CON, 8'h3E);
      @(negedge core_clk);
      cmp("pins_off", 8'h01, {card_c8, card_c4, card_rst, card_supply_on, 3'h0, card_io_oe_n});
   endtask
   // Receive, transmit with five, transmit with four
   task automatic t_parity();
      logic [1:0] s;
      for (int m = 0; m < 3; m++) begin
         soft_reset();
         pulse(7'h08, s);
         cmp("no_signal", 8'h00, {6'h00, s});
         wr(A_SEL, (m == 2) ? 8'h19 : 8'h09);
         wr(A_CTL, 8'h02);
         wr(A_SEL, (m == 2) ? 8'h18 : 8'h08);
         for (int i = 0; i < ((m == 1) ? 5 : 4); i++) begin
            chk(A_ST, 8'h80);
            pulse((m == 0) ? 7'h08 : 7'h04, s);
            cmp("signal", {7'h00, i < 3}, {7'h00, (m == 0) ? s[1] : s[0]});
         end
         chk(A_ST, 8'h81);
      end
   endtask
   task automatic t_wait();
      logic [1:0] s;
      soft_reset();
      wr(scic_pkg::ADDR_WT0, 8'h03);
      wr(scic_pkg::ADDR_WT1, 8'h00);
      wr(A_CTL, 8'h00);
      wr(A_SEL, 8'h09);
      wr(A_CTL, 8'h04);
      wr(A_SEL, 8'h08);
      for (int i = 0; i < 3; i++) begin
         chk(A_ST, 8'h80);
         pulse(7'h01, s);
      end
      chk(A_ST, 8'h88);
      cmp("abort", 8'h01, {7'h00, xfer_abort});
   endtask
   task automatic t_alt();
      int   e0, e;
      logic p;
      for (int k = 0; k < 4; k++) begin
         wr(A_SEL, {4'h0, k[1:0], 2'b10});
         p = alt_card_clock;
         e = 0;
         repeat (128) begin
            @(negedge core_clk);
            e += int'(alt_card_clock && !p);
            p = alt_card_clock;
         end
         if (k == 0) e0 = e;
         cmp("alt_div", 8'h01, {7'h00, e0 > 7 && (e + 1 - (e0 >> k)) inside {[0:2]}});
      end
      wr(A_SEL, 8'h08);
   endtask

   task automatic report_and_stop();
      $display("Checks %0d, mismatches %0d", check_count, err_count);
      if (err_count == 0 && check_count > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   initial begin
      #100000;
      err_count++;
      report_and_stop();
   end
   initial begin
      repeat (3) @(posedge core_clk);
      sys_rst <= 1'b0;
      @(negedge core_clk);
      t_buffer();
      t_irq();
      t_contacts();
      t_parity();
      t_wait();
      t_alt();
      report_and_stop();
   end
endmodule // test_smart_card_interface_control
